// [core/sac_port.sv]
/*
  Serial command port: address-mode frames of 16 bits, or 24 with CRC,
  register file, error flags and switch update at frame end.
  Assumes SCLK_I idles between frames and CS_N_I frames every transfer;
  MCLK_I is free running and much faster than the serial clock.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Works in SPI Mode 0 and Mode 3, serial clock up to 50 MHz.
// - Address mode from reset: one frame per chip select, 16 clocks.
// - CRC enabled makes every frame 24 bits long.
// - Input sampled on rising edges, output changed on falling edges.
// - Serial output is open drain: pulled low or high impedance.
// - First input bit: 0 means write, 1 means read.
// - Then seven address bits, then eight data bits.
// - On reads the last eight input bits are ignored.
// - Address is taken at the eighth rising edge.
// - Read data leaves on falling edges nine to sixteen in Mode 3, eight to fifteen in Mode 0.
// - Without CRC the write happens at the sixteenth rising edge.
// - First eight falling edges send the alignment byte 0x25 in Mode 3; in Mode 0 chip select and the first seven do.
// - Three error kinds, each with enable bit and flag bit.
// - Errors show only in the error flags register.
// - With CRC, eight extra clocks carry the frame's CRC byte.
// - CRC covers operation bit, seven address bits, eight data bits.
// - CRC polynomial x^8+x^2+x+1, seeded with zero.
// - With CRC the write happens at the twenty-fourth rising edge.
// - CRC checked at edge 24 on writes; mismatch blocks write, sets flag.
// - Reads with CRC send a CRC byte after the data.
// - CRC checking is off after reset and set by error config.
// - Switches take the new state when chip select rises.
// - Reset low opens all switches and restores register defaults.
module sac_port (
  // System clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Serial link from the host
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  // Switch and status outputs
  output logic [3:0] SW_O,
  output logic [2:0] ERR_FLAGS_O,
  output logic CRC_EN_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sac_pkg::sac_pos_t p_reg;
  sac_pkg::sac_pos_t p_next;
  sac_pkg::sac_link_t l_reg;
  sac_pkg::sac_link_t l_next;
  sac_pkg::sac_neg_t n_reg;
  sac_pkg::sac_neg_t n_next;
  sac_pkg::sac_mclk_t m_reg;
  sac_pkg::sac_mclk_t m_next;

  logic [6:0] addr_in;
  logic rw_in;
  logic [7:0] data_in;
  logic [7:0] rdata;
  logic [15:0] payload;
  logic [7:0] crc_rx;
  logic crc_ok;
  logic [4:0] evt;
  logic [23:0] stream;

  // Bits as they arrive; payload and received CRC share the shifter
  assign addr_in = {p_reg.shreg[5:0], SDI_I};
  assign rw_in = p_reg.shreg[6];
  assign data_in = {p_reg.shreg[6:0], SDI_I};
  assign payload = p_reg.shreg[22:7];
  assign crc_rx = {p_reg.shreg[6:0], SDI_I};
  assign crc_ok = (sac_pkg::sac_crc16(payload) == crc_rx);

  // Register read mux, fed by the snapshot held steady during frames
  always_comb begin
    rdata = 8'h00;
    case (addr_in)
      sac_pkg::SAC_ADDR_SW: rdata = {4'h0, m_reg.snap.sw};
      sac_pkg::SAC_ADDR_ERR_CFG: rdata = {5'h00, m_reg.snap.cfg};
      sac_pkg::SAC_ADDR_ERR_FLAGS: rdata = {5'h00, m_reg.snap.flags};
      default: rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial clock, rising edge: shift, decode, request
  // ----------------------------------------------------------------
  // Snapshot is read here as quasi-static: it only moves while deselected
  always_comb begin
    p_next = p_reg;
    l_next = l_reg;
    p_next.shreg = {p_reg.shreg[21:0], SDI_I};
    if (p_reg.bitcnt != sac_pkg::SAC_CNT_MAX) begin
      p_next.bitcnt = p_reg.bitcnt + 5'h01;
    end
    if (p_reg.bitcnt == 5'h00) begin
      p_next.crc_en = m_reg.snap.cfg[sac_pkg::SAC_ERR_CRC];
    end
    // Address stage at the eighth edge
    if (p_reg.bitcnt == sac_pkg::SAC_CNT_ADDR) begin
      p_next.rw = rw_in;
      p_next.addr = addr_in;
      p_next.addr_ok = sac_pkg::sac_addr_ok(addr_in, rw_in);
      if (rw_in) begin
        p_next.out_word = {rdata, sac_pkg::sac_crc16({1'b1, addr_in, rdata})};
      end else begin
        p_next.out_word = {sac_pkg::SAC_RELEASE, sac_pkg::SAC_RELEASE};
      end
      if (!sac_pkg::sac_addr_ok(addr_in, rw_in) &&
          m_reg.snap.cfg[sac_pkg::SAC_ERR_ADDR]) begin
        l_next.tgl[sac_pkg::SAC_EVT_ADDR] = ~l_reg.tgl[sac_pkg::SAC_EVT_ADDR];
      end
    end
    // Plain write at the sixteenth edge; read frames ignore the data bits
    if (p_reg.bitcnt == sac_pkg::SAC_CNT_WR && !p_reg.crc_en) begin
      if (!p_reg.rw && p_reg.addr_ok) begin
        l_next.tgl[sac_pkg::SAC_EVT_WR] = ~l_reg.tgl[sac_pkg::SAC_EVT_WR];
        l_next.wr_addr = p_reg.addr;
        l_next.wr_data = data_in;
      end
      l_next.tgl[sac_pkg::SAC_EVT_DONE] = ~l_reg.tgl[sac_pkg::SAC_EVT_DONE];
    end
    // Checked write at the twenty-fourth edge
    if (p_reg.bitcnt == sac_pkg::SAC_CNT_WR_CRC && p_reg.crc_en) begin
      if (!p_reg.rw) begin
        if (crc_ok) begin
          if (p_reg.addr_ok) begin
            l_next.tgl[sac_pkg::SAC_EVT_WR] = ~l_reg.tgl[sac_pkg::SAC_EVT_WR];
            l_next.wr_addr = p_reg.addr;
            l_next.wr_data = payload[7:0];
          end
        end else begin
          l_next.tgl[sac_pkg::SAC_EVT_CRC] = ~l_reg.tgl[sac_pkg::SAC_EVT_CRC];
        end
      end
      l_next.tgl[sac_pkg::SAC_EVT_DONE] = ~l_reg.tgl[sac_pkg::SAC_EVT_DONE];
    end
    // First surplus clock marks an over-long frame
    if (p_reg.bitcnt == (p_reg.crc_en ? sac_pkg::SAC_CNT_OVER_CRC : sac_pkg::SAC_CNT_OVER)) begin
      l_next.tgl[sac_pkg::SAC_EVT_OVER] = ~l_reg.tgl[sac_pkg::SAC_EVT_OVER];
    end
  end

  // Deselect clears the frame; the host keeps select low throughout
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

  // Toggles and write words survive deselect so the system side can see them
  always_ff @(posedge SCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial clock, falling edge: open-drain output
  // ----------------------------------------------------------------
  // Index is the rising-edge count, so Mode 0 and Mode 3 both line up
  always_comb begin
    stream = {sac_pkg::SAC_ALIGN, p_reg.out_word};
    n_next.oe_n = 1'b1;
    if (p_reg.bitcnt < sac_pkg::SAC_IDX_CRC ||
        (p_reg.crc_en && p_reg.bitcnt < sac_pkg::SAC_IDX_END)) begin
      n_next.oe_n = stream[5'd23 - p_reg.bitcnt];
    end
  end

  // Reset value is the alignment MSB, ready before the first falling edge
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      n_reg.oe_n <= sac_pkg::SAC_ALIGN[7];
    end else begin
      n_reg <= n_next;
    end
  end

  // Pin only ever pulls low; deselect releases it at once
  assign SDO_O = 1'b0;
  assign SDO_OE_N_O = CS_N_I | n_reg.oe_n;

  // ----------------------------------------------------------------
  // System clock: synchronisers, register file, switches
  // ----------------------------------------------------------------
  assign evt = m_reg.evt_q2 ^ m_reg.evt_seen;

  always_comb begin
    m_next = m_reg;
    m_next.cs_q = {m_reg.cs_q[0], CS_N_I};
    m_next.cs_d = m_reg.cs_q[1];
    m_next.evt_q1 = l_reg.tgl;
    m_next.evt_q2 = m_reg.evt_q1;
    m_next.evt_seen = m_reg.evt_q2;
    // Frame start clears the count trackers before any event of it lands
    if (m_reg.cs_d && !m_reg.cs_q[1]) begin
      m_next.done_seen = 1'b0;
      m_next.over_seen = 1'b0;
    end
    // Frame end waits so that toggles from the last edges have arrived
    if (!m_reg.cs_d && m_reg.cs_q[1]) begin
      m_next.eval_cnt = sac_pkg::SAC_EVAL_DELAY;
    end else if (m_reg.eval_cnt != 2'h0) begin
      m_next.eval_cnt = m_reg.eval_cnt - 2'h1;
    end
    if (m_reg.eval_cnt == 2'h1) begin
      m_next.sw_out = m_reg.sw_data;
      if (m_reg.err_cfg[sac_pkg::SAC_ERR_SCLK] && (!m_reg.done_seen || m_reg.over_seen)) begin
        m_next.err_flags[sac_pkg::SAC_ERR_SCLK] = 1'b1;
      end
    end
    // Write words are stable once their toggle has been synchronised
    if (evt[sac_pkg::SAC_EVT_WR]) begin
      if (l_reg.wr_addr == sac_pkg::SAC_ADDR_SW) begin
        m_next.sw_data = l_reg.wr_data[3:0];
      end
      if (l_reg.wr_addr == sac_pkg::SAC_ADDR_ERR_CFG) begin
        m_next.err_cfg = l_reg.wr_data[2:0];
      end
    end
    if (evt[sac_pkg::SAC_EVT_CRC]) begin
      m_next.err_flags[sac_pkg::SAC_ERR_CRC] = 1'b1;
    end
    if (evt[sac_pkg::SAC_EVT_ADDR]) begin
      m_next.err_flags[sac_pkg::SAC_ERR_ADDR] = 1'b1;
    end
    if (evt[sac_pkg::SAC_EVT_DONE]) begin
      m_next.done_seen = 1'b1;
    end
    if (evt[sac_pkg::SAC_EVT_OVER]) begin
      m_next.over_seen = 1'b1;
    end
    // Snapshot moves only while deselected, keeping reads coherent
    if (m_reg.cs_q[1]) begin
      m_next.snap = '{sw: m_reg.sw_data, cfg: m_reg.err_cfg, flags: m_reg.err_flags};
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      m_reg <= '0;
      m_reg.cs_q <= 2'h3;
      m_reg.cs_d <= 1'b1;
      m_reg.sw_data <= sac_pkg::SAC_SW_RST;
      m_reg.sw_out <= sac_pkg::SAC_SW_RST;
      m_reg.err_cfg <= sac_pkg::SAC_ERR_CFG_RST;
      m_reg.err_flags <= sac_pkg::SAC_ERR_FLAGS_RST;
    end else begin
      m_reg <= m_next;
    end
  end

  assign SW_O = m_reg.sw_out;
  assign ERR_FLAGS_O = m_reg.err_flags;
  assign CRC_EN_O = m_reg.err_cfg[sac_pkg::SAC_ERR_CRC];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ALIGN_OUT: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.bitcnt <= sac_pkg::SAC_CNT_ADDR) |->
      (SDO_OE_N_O == sac_pkg::SAC_ALIGN[3'(5'd7 - p_reg.bitcnt)]))
    else $error("alignment bit wrong on serial output");

  AST_READ_DATA: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.rw && p_reg.bitcnt > sac_pkg::SAC_CNT_ADDR && p_reg.bitcnt <= sac_pkg::SAC_CNT_WR) |->
      (SDO_OE_N_O == p_reg.out_word[4'(5'd23 - p_reg.bitcnt)]))
    else $error("read data bit wrong on serial output");

  AST_ADDR_LATCH: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.bitcnt == sac_pkg::SAC_CNT_ADDR) |=> (p_reg.addr == $past(addr_in)))
    else $error("address not taken at eighth edge");

  AST_PLAIN_WRITE: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.bitcnt == sac_pkg::SAC_CNT_WR && !p_reg.crc_en && !p_reg.rw && p_reg.addr_ok) |->
      (((l_next.tgl ^ l_reg.tgl) & sac_pkg::SAC_EVT_M_WR) == sac_pkg::SAC_EVT_M_WR))
    else $error("write missing at sixteenth edge");

  AST_NO_EARLY_WRITE: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.crc_en && p_reg.bitcnt != sac_pkg::SAC_CNT_WR_CRC) |->
      ((l_next.tgl & sac_pkg::SAC_EVT_M_WR) == (l_reg.tgl & sac_pkg::SAC_EVT_M_WR)))
    else $error("checked write outside the twenty-fourth edge");

  AST_CRC_BLOCK: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.bitcnt == sac_pkg::SAC_CNT_WR_CRC && p_reg.crc_en && !p_reg.rw && !crc_ok) |->
      (((l_next.tgl ^ l_reg.tgl) & (sac_pkg::SAC_EVT_M_WR | sac_pkg::SAC_EVT_M_CRC)) ==
        sac_pkg::SAC_EVT_M_CRC))
    else $error("bad CRC did not block write and raise error");

  AST_RELEASE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    CS_N_I |-> (SDO_OE_N_O && p_reg.bitcnt == 5'h00))
    else $error("serial output driven or count kept while deselected");

  AST_RESET_OPEN: assert property (@(posedge MCLK_I)
    !RST_N_I |=> (SW_O == sac_pkg::SAC_SW_RST && ERR_FLAGS_O == sac_pkg::SAC_ERR_FLAGS_RST))
    else $error("reset did not open switches or clear flags");

  AST_CRC_OFF: assert property (@(posedge MCLK_I)
    !RST_N_I |=> !CRC_EN_O)
    else $error("CRC checking on after reset");

  AST_SW_HOLD: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (!m_reg.cs_q[1] && m_reg.eval_cnt == 2'h0) |=> $stable(SW_O))
    else $error("switches changed inside a frame");

  AST_SW_APPLY: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (m_reg.eval_cnt == 2'h1) |=> (SW_O == $past(m_reg.sw_data)))
    else $error("switches not updated at frame end");

  AST_FLAGS_STICKY: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    ((ERR_FLAGS_O & $past(ERR_FLAGS_O)) == $past(ERR_FLAGS_O)))
    else $error("error flag dropped without reset");

  AST_CRC_FLAG: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    evt[sac_pkg::SAC_EVT_CRC] |=> ERR_FLAGS_O[sac_pkg::SAC_ERR_CRC])
    else $error("CRC error not flagged");

  AST_ADDR_FLAG: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    evt[sac_pkg::SAC_EVT_ADDR] |=> ERR_FLAGS_O[sac_pkg::SAC_ERR_ADDR])
    else $error("invalid address not flagged");

  AST_COUNT_FLAG: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (m_reg.eval_cnt == 2'h1 && m_reg.err_cfg[sac_pkg::SAC_ERR_SCLK] && m_reg.over_seen) |=>
      ERR_FLAGS_O[sac_pkg::SAC_ERR_SCLK])
    else $error("over-long frame not flagged");

  AST_WRITE_QUIET: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (!p_reg.rw && p_reg.bitcnt > sac_pkg::SAC_CNT_ADDR &&
      p_reg.bitcnt < sac_pkg::SAC_IDX_CRC) |-> SDO_OE_N_O)
    else $error("serial output pulled low during write data");

  AST_CRC_READ_OUT: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.rw && p_reg.crc_en && p_reg.bitcnt >= sac_pkg::SAC_IDX_CRC &&
      p_reg.bitcnt < sac_pkg::SAC_IDX_END) |->
      (SDO_OE_N_O == p_reg.out_word[4'(5'd23 - p_reg.bitcnt)]))
    else $error("read CRC bit wrong on serial output");

  AST_CRC_WRITE: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.bitcnt == sac_pkg::SAC_CNT_WR_CRC && p_reg.crc_en && !p_reg.rw && crc_ok &&
      p_reg.addr_ok) |->
      (((l_next.tgl ^ l_reg.tgl) & sac_pkg::SAC_EVT_M_WR) == sac_pkg::SAC_EVT_M_WR))
    else $error("checked write missing at twenty-fourth edge");

  AST_READ_NO_WRITE: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.rw && p_reg.bitcnt > sac_pkg::SAC_CNT_ADDR) |->
      ((l_next.tgl & sac_pkg::SAC_EVT_M_WR) == (l_reg.tgl & sac_pkg::SAC_EVT_M_WR)))
    else $error("read frame caused a register write");

  AST_ADDR_ERR: assert property (@(posedge SCLK_I) disable iff (CS_N_I)
    (p_reg.bitcnt == sac_pkg::SAC_CNT_ADDR && !sac_pkg::sac_addr_ok(addr_in, rw_in) &&
      m_reg.snap.cfg[sac_pkg::SAC_ERR_ADDR]) |->
      (l_next.tgl[sac_pkg::SAC_EVT_ADDR] != l_reg.tgl[sac_pkg::SAC_EVT_ADDR]))
    else $error("invalid address not reported to the system side");

  COV_READ: cover property (@(posedge SCLK_I) disable iff (CS_N_I)
    p_reg.rw && p_reg.bitcnt == sac_pkg::SAC_CNT_WR);
  COV_CRC_WRITE: cover property (@(posedge SCLK_I) disable iff (CS_N_I)
    p_reg.crc_en && !p_reg.rw && crc_ok && p_reg.bitcnt == sac_pkg::SAC_CNT_WR_CRC);
  COV_CRC_ERR: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(ERR_FLAGS_O[sac_pkg::SAC_ERR_CRC]));
  COV_SCLK_ERR: cover property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(ERR_FLAGS_O[sac_pkg::SAC_ERR_SCLK]));
  COV_LONG_FRAME: cover property (@(posedge SCLK_I) disable iff (CS_N_I)
    !p_reg.crc_en && p_reg.bitcnt == sac_pkg::SAC_CNT_OVER);

endmodule

// [inc/sac_pkg.sv]
/*
  Shared constants, state carriers and helper functions for the serial
  address-mode command port with optional CRC.
  Assumes one system clock and one serial clock from the host.
*/
package sac_pkg;

  // ----------------------------------------------------------------
  // Frame positions (rising-edge count before the edge in question)
  // ----------------------------------------------------------------
  localparam logic [4:0] SAC_CNT_ADDR = 5'h07;     // Eighth rising edge
  localparam logic [4:0] SAC_CNT_WR = 5'h0F;       // Sixteenth rising edge
  localparam logic [4:0] SAC_CNT_WR_CRC = 5'h17;   // Twenty-fourth rising edge
  localparam logic [4:0] SAC_CNT_OVER = 5'h10;     // First surplus edge, plain
  localparam logic [4:0] SAC_CNT_OVER_CRC = 5'h18; // First surplus edge, CRC
  localparam logic [4:0] SAC_CNT_MAX = 5'h1F;
  localparam logic [4:0] SAC_IDX_CRC = 5'h10;      // First CRC bit on output
  localparam logic [4:0] SAC_IDX_END = 5'h18;      // Past the last output bit

  // ----------------------------------------------------------------
  // Serial coding
  // ----------------------------------------------------------------
  localparam logic [7:0] SAC_ALIGN = 8'h25;
  localparam logic [7:0] SAC_CRC_POLY = 8'h07;     // x^8 + x^2 + x + 1
  localparam logic [7:0] SAC_CRC_SEED = 8'h00;
  localparam logic [7:0] SAC_RELEASE = 8'hFF;      // Output left to the pull-up

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [6:0] SAC_ADDR_SW = 7'h01;
  localparam logic [6:0] SAC_ADDR_ERR_CFG = 7'h02;
  localparam logic [6:0] SAC_ADDR_ERR_FLAGS = 7'h03;
  localparam int SAC_ERR_CRC = 0;
  localparam int SAC_ERR_SCLK = 1;
  localparam int SAC_ERR_ADDR = 2;
  localparam logic [3:0] SAC_SW_RST = 4'h0;
  localparam logic [2:0] SAC_ERR_CFG_RST = 3'h6;   // Count and address on, CRC off
  localparam logic [2:0] SAC_ERR_FLAGS_RST = 3'h0;

  // ----------------------------------------------------------------
  // Event toggles crossing from the serial clock
  // ----------------------------------------------------------------
  localparam int SAC_EVT_WR = 0;
  localparam int SAC_EVT_CRC = 1;
  localparam int SAC_EVT_ADDR = 2;
  localparam int SAC_EVT_DONE = 3;
  localparam int SAC_EVT_OVER = 4;
  localparam logic [4:0] SAC_EVT_M_WR = 5'h01;
  localparam logic [4:0] SAC_EVT_M_CRC = 5'h02;
  localparam logic [1:0] SAC_EVAL_DELAY = 2'h3;    // Lets late toggles land

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sw;
    logic [2:0] cfg;
    logic [2:0] flags;
  } sac_snap_t;

  typedef struct packed {
    logic [4:0] bitcnt;
    logic [22:0] shreg;
    logic rw;
    logic [6:0] addr;
    logic addr_ok;
    logic crc_en;
    logic [15:0] out_word;
  } sac_pos_t;

  typedef struct packed {
    logic [4:0] tgl;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
  } sac_link_t;

  typedef struct packed {
    logic oe_n;
  } sac_neg_t;

  typedef struct packed {
    logic [1:0] cs_q;
    logic cs_d;
    logic [4:0] evt_q1;
    logic [4:0] evt_q2;
    logic [4:0] evt_seen;
    logic [1:0] eval_cnt;
    logic done_seen;
    logic over_seen;
    logic [3:0] sw_data;
    logic [3:0] sw_out;
    logic [2:0] err_cfg;
    logic [2:0] err_flags;
    sac_snap_t snap;
  } sac_mclk_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // CRC over a 16-bit payload, most significant bit first
  function automatic logic [7:0] sac_crc16(input logic [15:0] w);
    logic [7:0] c;
    logic fb;
    c = SAC_CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ w[i];
      c = {c[6:0], 1'b0} ^ (fb ? SAC_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Flags register is read-only, so a write to it counts as invalid
  function automatic logic sac_addr_ok(input logic [6:0] a, input logic rd);
    return (a == SAC_ADDR_SW) || (a == SAC_ADDR_ERR_CFG) ||
           (rd && (a == SAC_ADDR_ERR_FLAGS));
  endfunction

endpackage

// [test/sac_host_model.sv]
/*
  Behavioural SPI host that drives command frames into the serial port.
  Assumes the bench resolves the open-drain return with a pull-up.
*/
`timescale 1ns/1ps
module sac_host_model (
  // Serial link towards the port
  output logic SCLK_O,
  output logic CS_N_O,
  output logic SDI_O,
  // Resolved data return
  input wire logic SDO_I
);
  // ----------------------------------------------------------------
  // Link idle state
  // ----------------------------------------------------------------
  initial begin
    SCLK_O = 1'b0;
    CS_N_O = 1'b0;
    SDI_O = 1'b0;
    #1 CS_N_O = 1'b1; // A real deselect edge clears the port's frame state
  end

  // CRC over the payload, zero seed, first-sent bit first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // One frame, 160 ns clock; outside the frame the clock only rises to idle high for Mode 3 and drops back low after deselect
  // ----------------------------------------------------------------
  // A corrupted CRC is sent only when the bench asks for it
  task automatic xfer(input logic [15:0] w, input int n, input logic bad, input logic m3,
                      output logic [23:0] rx);
    logic [23:0] f;
    f = {w, crc8(w) ^ {7'h00, bad}};
    rx = 24'h000000;
    SCLK_O = m3;
    #37 CS_N_O = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      if (m3) SCLK_O = 1'b0;
      SDI_O = f[23 - i];
      #80 rx[23 - i] = SDO_I;
      SCLK_O = 1'b1;
      #80 if (!m3) SCLK_O = 1'b0;
    end
    #40 CS_N_O = 1'b1;
    SDI_O = ~SDI_O; // Stale data must not look meaningful
    #40 SCLK_O = 1'b0;
    #200;
  endtask
endmodule

// [test/sac_port_tb_top.sv]
/*
  Self-checking bench for the serial command port.
  Assumes the host model drives the link and a pull-up on the data return.
*/
`timescale 1ns/1ps
module sac_port_tb_top;
  logic mclk;
  logic rst_n;
  wire logic sclk;
  wire logic cs_n;
  wire logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic [3:0] sw;
  logic [2:0] flags;
  logic crc_en;
  wire logic sdo_line;
  logic [23:0] rx;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  // Pull-up: a released line reads high
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;

  sac_port uut (
    .MCLK_I(mclk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .SDI_I(sdi),
    .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .SW_O(sw), .ERR_FLAGS_O(flags), .CRC_EN_O(crc_en)
  );

  sac_host_model host (.SCLK_O(sclk), .CS_N_O(cs_n), .SDI_O(sdi), .SDO_I(sdo_line));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // About 11 frames of up to 4.2 us each; the ceiling leaves a wide margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({sw, flags, crc_en, sdo_oe_n}, {4'h0, 3'h0, 1'b0, 1'b1});
  endtask

  // Switches must hold old state between the last edge and deselect
  task automatic t_write_plain();
    fork
      host.xfer(16'h0105, 16, 1'b0, 1'b0, rx);
      begin
        #2620;
        check(sw, 4'h0);
      end
    join
    check(rx[23:8], {8'h25, 8'hFF});
    check({sw, sdo_oe_n}, {4'h5, 1'b1});
  endtask

  // Non-zero trailing input bits must not disturb the register
  task automatic t_read_plain();
    host.xfer(16'h81AA, 16, 1'b0, 1'b0, rx);
    check(rx[23:8], 16'h2505);
    check(sw, 4'h5);
  endtask

  task automatic t_errors();
    host.xfer(16'h7F0F, 16, 1'b0, 1'b0, rx);
    check({sw, flags}, {4'h5, 3'b100});
    host.xfer(16'h010F, 12, 1'b0, 1'b0, rx);
    check({sw, flags}, {4'h5, 3'b110});
  endtask

  task automatic t_crc();
    host.xfer(16'h0207, 16, 1'b0, 1'b0, rx);
    check(crc_en, 1'b1);
    host.xfer(16'h010A, 24, 1'b0, 1'b0, rx);
    check({sw, flags, rx[15:0]}, {4'hA, 3'b110, 16'hFFFF});
    host.xfer(16'h0103, 24, 1'b1, 1'b0, rx);
    check({sw, flags}, {4'hA, 3'b111});
    host.xfer(16'h8155, 24, 1'b0, 1'b1, rx);
    check(rx, {8'h25, 8'h0A, host.crc8(16'h810A)});
    host.xfer(16'h8300, 24, 1'b0, 1'b0, rx);
    check(rx[15:8], 8'h07);
  endtask

  // Reset in mid-run must drop CRC framing back to 16 bits
  task automatic t_mid_reset();
    @(posedge mclk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    check({sw, flags, crc_en}, 8'h00);
    host.xfer(16'h0109, 16, 1'b0, 1'b0, rx);
    check({sw, flags}, {4'h9, 3'b000});
    host.xfer(16'h0103, 20, 1'b0, 1'b0, rx);
    check({sw, flags}, {4'h3, 3'b010});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b1;
    #1 rst_n = 1'b0; // A real falling edge so the link-side toggles clear too
    repeat (6) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    t_reset();
    t_write_plain();
    t_read_plain();
    t_errors();
    t_crc();
    t_mid_reset();
    complete_run();
  end
endmodule
